// ---- hw/ssmc_pkg.sv ----
// Functional notes
// R1 - Reset input clears all internal registers
// R2 - First control write after reset is mode
// R3 - Next control writes load sync patterns
// R4 - Later control writes decode as commands
// R5 - Commands accepted anytime, act at once
// R6 - Command internal-reset bit returns to mode
// R7 - Data port select low, control select high
// R8 - Control address primary or alternate set
// R9 - Host writes zero in mode bits 1:0
// R10 - Mode bits 3:2 set character length
// R11 - Mode bit 4 enables parity gen/check
// R12 - Mode bit 5 high selects even parity
// R13 - Mode bit 6 makes sync_found an input
// R14 - Mode bit 7 low: two sync characters
// R15 - Command bit 0 enables transmitter
// R16 - Command bit 1 drives terminal-ready inverted
// R17 - Command bit 2 enables receiver
// R18 - Host keeps break request bit low
// R19 - Command bit 4 clears error flags
// R20 - Command bit 5 drives request-to-send inverted
// R21 - Command bit 7 enters hunt mode
// R22 - Hunt compares every bit, then second char
// R23 - Sync found sets status, read clears it; code sets status only on an internal sync match, never from sync_found_in
// R24 - Length code 00..11 means 5..8 bits
// R25 - Break bit holds transmit line at space
package ssmc_pkg;
    // ------------------------------------------------
    // Addresses
    // ------------------------------------------------
    localparam logic [9:0] SSMC_DATA_PRI = 10'h3A8;
    localparam logic [9:0] SSMC_CTRL_PRI = 10'h3A9;
    localparam logic [9:0] SSMC_DATA_ALT = 10'h388;
    localparam logic [9:0] SSMC_CTRL_ALT = 10'h389;
    // ------------------------------------------------
    // Field positions
    // ------------------------------------------------
    localparam int MODE_LEN_LO = 2;
    localparam int MODE_PAR_EN = 4;
    localparam int MODE_PAR_EVEN = 5;
    localparam int MODE_EXT_SYNC = 6;
    localparam int MODE_SINGLE = 7;
    localparam int CMD_TX_EN = 0;
    localparam int CMD_DTR = 1;
    localparam int CMD_RX_EN = 2;
    localparam int CMD_BREAK = 3;
    localparam int CMD_ERR_RST = 4;
    localparam int CMD_RTS = 5;
    localparam int CMD_IRESET = 6;
    localparam int CMD_HUNT = 7;
    localparam int ST_TXRDY = 0;
    localparam int ST_RXRDY = 1;
    localparam int ST_TXEMPTY = 2;
    localparam int ST_PE = 3;
    localparam int ST_OE = 4;
    localparam int ST_SYNC = 6;
    localparam int ST_DSR = 7;
    localparam logic [7:0] SSMC_BYTE_ZERO = 8'h00;
    localparam logic [7:0] SSMC_MARK_BYTE = 8'hFF;
    localparam logic [3:0] SSMC_LEN_BASE = 4'h5;
    localparam logic [3:0] SSMC_CNT_ZERO = 4'h0;

    // Control write sequencing
    typedef enum logic [1:0] {
        SSMC_ST_MODE,
        SSMC_ST_SYNC1,
        SSMC_ST_SYNC2,
        SSMC_ST_CMD
    } ssmc_seq_e;

    // Settings sent to the link domain
    typedef struct packed {
        logic [1:0] len;
        logic par_en;
        logic par_even;
        logic ext_sync;
        logic single;
        logic tx_en;
        logic rx_en;
        logic brk;
        logic [7:0] sync1;
        logic [7:0] sync2;
    } ssmc_cfg_s;
endpackage

// ---- hw/ssmc_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssmc_core (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic alt_sel,
    input wire logic [9:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic link_clk,
    input wire logic rx_line,
    output logic tx_line,
    input wire logic dsr_n,
    output logic dtr_n,
    output logic rts_n,
    input wire logic sync_found_in,
    output logic sync_found_out,
    output logic sync_found_oe_n
);
    import ssmc_pkg::*;

    // ------------------------------------------------
    // Host side decode
    // ------------------------------------------------
    // Strobes are synchronous to ref_clk (same-domain host)
    logic [9:0] data_adr;
    logic [9:0] ctrl_adr;
    logic ctl_wr;
    logic dat_wr;
    logic ctl_rd;
    logic dat_rd;
    assign data_adr = alt_sel ? SSMC_DATA_ALT : SSMC_DATA_PRI; // R7
    assign ctrl_adr = alt_sel ? SSMC_CTRL_ALT : SSMC_CTRL_PRI; // R8
    assign ctl_wr = wr_stb && (addr == ctrl_adr);
    assign dat_wr = wr_stb && (addr == data_adr);
    assign ctl_rd = rd_stb && (addr == ctrl_adr);
    assign dat_rd = rd_stb && (addr == data_adr);

    ssmc_seq_e seq_reg;
    logic [7:0] mode_reg;
    logic [7:0] cmd_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic ireset;
    assign ireset = ctl_wr && (seq_reg == SSMC_ST_CMD) && wr_data[CMD_IRESET];

    // ------------------------------------------------
    // Control write sequencer
    // ------------------------------------------------
    // Mode, then one or two syncs, then commands
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            seq_reg <= SSMC_ST_MODE; // R1
        end else if (ctl_wr) begin
            case (seq_reg)
                SSMC_ST_MODE: seq_reg <= SSMC_ST_SYNC1; // R2
                SSMC_ST_SYNC1: seq_reg <= mode_reg[MODE_SINGLE] ?
                    SSMC_ST_CMD : SSMC_ST_SYNC2; // R3 R14
                SSMC_ST_SYNC2: seq_reg <= SSMC_ST_CMD; // R4
                SSMC_ST_CMD: begin
                    if (wr_data[CMD_IRESET]) begin
                        seq_reg <= SSMC_ST_MODE; // R6
                    end
                end
                default: seq_reg <= SSMC_ST_MODE;
            endcase
        end
    end

    // Mode and sync registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_reg <= SSMC_BYTE_ZERO; // R1
            sync1_reg <= SSMC_BYTE_ZERO;
            sync2_reg <= SSMC_BYTE_ZERO;
        end else if (ctl_wr && seq_reg == SSMC_ST_MODE) begin
            mode_reg <= wr_data; // R2
        end else if (ctl_wr && seq_reg == SSMC_ST_SYNC1) begin
            sync1_reg <= wr_data; // R3
        end else if (ctl_wr && seq_reg == SSMC_ST_SYNC2) begin
            sync2_reg <= wr_data; // R3
        end
    end

    // Command register; takes effect on the write itself
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_reg <= SSMC_BYTE_ZERO;
        end else if (ireset) begin
            cmd_reg <= SSMC_BYTE_ZERO; // R6
        end else if (ctl_wr && seq_reg == SSMC_ST_CMD) begin
            cmd_reg <= wr_data; // R4 R5
        end
    end

    // Modem control outputs, inverting ports
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
        end else begin
            dtr_n <= ~cmd_reg[CMD_DTR]; // R16
            rts_n <= ~cmd_reg[CMD_RTS]; // R20
        end
    end

    // ------------------------------------------------
    // Crossings
    // ------------------------------------------------
    // Config is quasi-static; written before rx/tx enabled
    ssmc_cfg_s cfg;
    ssmc_cfg_s cfg_m_reg;
    ssmc_cfg_s cfg_l_reg;
    assign cfg = '{len: mode_reg[MODE_LEN_LO +: 2],
        par_en: mode_reg[MODE_PAR_EN], par_even: mode_reg[MODE_PAR_EVEN],
        ext_sync: mode_reg[MODE_EXT_SYNC], single: mode_reg[MODE_SINGLE],
        tx_en: cmd_reg[CMD_TX_EN], rx_en: cmd_reg[CMD_RX_EN],
        brk: cmd_reg[CMD_BREAK], sync1: sync1_reg, sync2: sync2_reg};

    // Hunt request and host events travel as toggles
    logic hunt_tgl_reg;
    logic txw_tgl_reg;
    logic link_rst_m_reg;
    logic link_rst_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hunt_tgl_reg <= 1'b0;
            txw_tgl_reg <= 1'b0;
        end else begin
            if (ctl_wr && seq_reg == SSMC_ST_CMD && wr_data[CMD_HUNT]) begin
                hunt_tgl_reg <= ~hunt_tgl_reg; // R21
            end
            if (dat_wr) begin
                txw_tgl_reg <= ~txw_tgl_reg;
            end
        end
    end

    logic [7:0] tx_hold_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_hold_reg <= SSMC_BYTE_ZERO;
        end else if (dat_wr) begin
            tx_hold_reg <= wr_data; // R7
        end
    end

    // Link-domain reset follows host reset or internal reset
    logic link_rst_src_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            link_rst_src_reg <= 1'b1;
        end else begin
            link_rst_src_reg <= ireset || (seq_reg != SSMC_ST_CMD);
        end
    end

    // Sync the level-type inputs into link domain
    logic hunt_m_reg, hunt_s_reg, hunt_d_reg;
    logic txw_m_reg, txw_s_reg, txw_d_reg;
    logic rxd_m_reg, rxd_s_reg;
    logic esy_m_reg, esy_s_reg;
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            cfg_m_reg <= '0;
            cfg_l_reg <= '0;
            link_rst_m_reg <= 1'b1;
            link_rst_reg <= 1'b1;
            hunt_m_reg <= 1'b0;
            hunt_s_reg <= 1'b0;
            hunt_d_reg <= 1'b0;
            txw_m_reg <= 1'b0;
            txw_s_reg <= 1'b0;
            txw_d_reg <= 1'b0;
            rxd_m_reg <= 1'b1;
            rxd_s_reg <= 1'b1;
            esy_m_reg <= 1'b0;
            esy_s_reg <= 1'b0;
        end else begin
            cfg_m_reg <= cfg;
            cfg_l_reg <= cfg_m_reg;
            link_rst_m_reg <= link_rst_src_reg;
            link_rst_reg <= link_rst_m_reg;
            hunt_m_reg <= hunt_tgl_reg;
            hunt_s_reg <= hunt_m_reg;
            hunt_d_reg <= hunt_s_reg;
            txw_m_reg <= txw_tgl_reg;
            txw_s_reg <= txw_m_reg;
            txw_d_reg <= txw_s_reg;
            rxd_m_reg <= rx_line;
            rxd_s_reg <= rxd_m_reg;
            esy_m_reg <= sync_found_in;
            esy_s_reg <= esy_m_reg;
        end
    end

    // ------------------------------------------------
    // Link domain: transmitter
    // ------------------------------------------------
    // Character length 5..8 from code 00..11
    logic [3:0] clen;
    assign clen = SSMC_LEN_BASE + {2'b00, cfg_l_reg.len}; // R10 R24

    function automatic logic par_of(input logic [7:0] d,
            input logic [3:0] n, input logic even);
        logic p;
        p = ~even; // R12
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction

    logic [8:0] tx_sh_reg;
    logic [3:0] tx_cnt_reg;
    logic [7:0] tx_buf_reg;
    logic tx_full_reg;
    logic tx_started_reg;
    logic [3:0] tx_bits;
    assign tx_bits = clen + {3'b000, cfg_l_reg.par_en};
    logic tx_load;
    // Reload on the last bit so characters run back to back
    assign tx_load = cfg_l_reg.tx_en && (tx_full_reg || tx_started_reg) &&
        (tx_cnt_reg <= 4'h1); // R15
    // Falls back to sync1 when the host runs dry
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            tx_sh_reg <= 9'h1FF;
            tx_cnt_reg <= SSMC_CNT_ZERO;
            tx_buf_reg <= SSMC_BYTE_ZERO;
            tx_full_reg <= 1'b0;
            tx_started_reg <= 1'b0;
            tx_line <= 1'b1;
        end else if (link_rst_reg) begin
            tx_full_reg <= 1'b0;
            tx_started_reg <= 1'b0;
            tx_cnt_reg <= SSMC_CNT_ZERO;
            tx_line <= 1'b1; // R1
        end else begin
            if (tx_load) begin // R15
                tx_started_reg <= 1'b1;
                tx_full_reg <= 1'b0;
                tx_sh_reg <= load_char(tx_full_reg ? tx_buf_reg :
                    cfg_l_reg.sync1);
                tx_cnt_reg <= tx_bits;
            end else if (tx_cnt_reg != SSMC_CNT_ZERO) begin
                tx_sh_reg <= {1'b1, tx_sh_reg[8:1]};
                tx_cnt_reg <= tx_cnt_reg - 4'h1;
            end
            // After the load: a byte arriving on a reload edge is kept
            if (txw_s_reg != txw_d_reg) begin
                tx_buf_reg <= tx_hold_reg;
                tx_full_reg <= 1'b1;
            end
            if (cfg_l_reg.brk) begin
                tx_line <= 1'b0; // R25
            end else if (tx_cnt_reg != SSMC_CNT_ZERO) begin
                tx_line <= tx_sh_reg[0];
            end else begin
                tx_line <= 1'b1;
            end
        end
    end

    function automatic logic [8:0] load_char(input logic [7:0] d);
        logic [8:0] v;
        v = {1'b1, d};
        v[clen] = cfg_l_reg.par_en ?
            par_of(d, clen, cfg_l_reg.par_even) : 1'b1; // R11
        return v;
    endfunction

    a_break_space: assert property (@(posedge link_clk) // R25
        disable iff (reset || link_rst_reg)
        cfg_l_reg.brk |=> !tx_line)
        else $error("break did not hold the line at space");

    // ------------------------------------------------
    // Link domain: receiver and hunt
    // ------------------------------------------------
    logic [8:0] rx_sh_reg;
    logic [3:0] rx_cnt_reg;
    logic hunt_reg;
    logic second_reg;
    logic [7:0] rx_char_reg;
    logic rx_tgl_reg;
    logic rx_perr_reg;
    logic sync_tgl_reg;
    logic [8:0] rx_nx;
    logic [7:0] rx_win;
    logic [7:0] len_mask;
    assign rx_nx = {rxd_s_reg, rx_sh_reg[8:1]};
    assign len_mask = SSMC_MARK_BYTE >> (4'h8 - clen);
    // Window aligned to the char just shifted in
    assign rx_win = 8'(rx_nx >> (4'h9 - clen)) & len_mask;

    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            rx_sh_reg <= '0;
            rx_cnt_reg <= SSMC_CNT_ZERO;
            hunt_reg <= 1'b0;
            second_reg <= 1'b0;
            rx_char_reg <= SSMC_BYTE_ZERO;
            rx_tgl_reg <= 1'b0;
            rx_perr_reg <= 1'b0;
            sync_tgl_reg <= 1'b0;
            sync_found_out <= 1'b0;
        end else if (link_rst_reg) begin
            hunt_reg <= 1'b0;
            second_reg <= 1'b0;
            sync_found_out <= 1'b0;
        end else begin
            rx_sh_reg <= rx_nx;
            if (hunt_s_reg != hunt_d_reg) begin
                hunt_reg <= 1'b1; // R21
                second_reg <= 1'b0;
                sync_found_out <= 1'b0;
            end else if (!cfg_l_reg.rx_en) begin
                rx_cnt_reg <= SSMC_CNT_ZERO; // R17
            end else if (hunt_reg && cfg_l_reg.ext_sync) begin
                if (esy_s_reg) begin
                    hunt_reg <= 1'b0; // R13
                    rx_cnt_reg <= SSMC_CNT_ZERO;
                end
            end else if (hunt_reg && !second_reg) begin
                if (rx_win == (cfg_l_reg.sync1 & len_mask)) begin // R22
                    second_reg <= !cfg_l_reg.single; // R14
                    hunt_reg <= !cfg_l_reg.single;
                    rx_cnt_reg <= SSMC_CNT_ZERO;
                    if (cfg_l_reg.single) begin
                        sync_tgl_reg <= ~sync_tgl_reg;
                        sync_found_out <= 1'b1;
                    end
                end
            end else if (rx_cnt_reg + 4'h1 == tx_bits) begin
                rx_cnt_reg <= SSMC_CNT_ZERO;
                if (second_reg) begin
                    second_reg <= 1'b0;
                    if (rx_win == (cfg_l_reg.sync2 & len_mask)) begin // R22
                        hunt_reg <= 1'b0;
                        sync_tgl_reg <= ~sync_tgl_reg; // R23
                        sync_found_out <= 1'b1;
                    end
                end else begin
                    rx_char_reg <= cfg_l_reg.par_en ?
                        8'(rx_nx >> (4'h9 - tx_bits)) & len_mask : rx_win;
                    rx_perr_reg <= cfg_l_reg.par_en && (par_of(
                        8'(rx_nx >> (4'h9 - tx_bits)), clen,
                        cfg_l_reg.par_even) != rxd_s_reg); // R11
                    rx_tgl_reg <= ~rx_tgl_reg;
                end
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
        end
    end

    // ------------------------------------------------
    // Host side status
    // ------------------------------------------------
    logic rx_m_reg, rx_s_reg, rx_d_reg;
    logic sy_m_reg, sy_s_reg, sy_d_reg;
    logic ds_m_reg, ds_s_reg;
    logic tk_m_reg, tk_s_reg;
    logic tx_busy_reg;
    logic rxrdy_reg, pe_reg, oe_reg, syn_reg;
    logic [7:0] rx_data_reg;
    logic rx_ev, sy_ev;
    assign rx_ev = rx_s_reg != rx_d_reg;
    assign sy_ev = sy_s_reg != sy_d_reg;
    // Char and parity flag are stable long before toggle lands
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {rx_m_reg, rx_s_reg, rx_d_reg} <= 3'b000;
            {sy_m_reg, sy_s_reg, sy_d_reg} <= 3'b000;
            {ds_m_reg, ds_s_reg} <= 2'b11;
            {tk_m_reg, tk_s_reg} <= 2'b00;
        end else begin
            {rx_m_reg, rx_s_reg, rx_d_reg} <= {rx_tgl_reg, rx_m_reg, rx_s_reg};
            {sy_m_reg, sy_s_reg, sy_d_reg} <= {sync_tgl_reg, sy_m_reg, sy_s_reg};
            {ds_m_reg, ds_s_reg} <= {dsr_n, ds_m_reg};
            // Link side acknowledge of a data write, brought back
            {tk_m_reg, tk_s_reg} <= {txw_d_reg, tk_m_reg};
        end
    end

    // Flags: event set wins over read and error-reset clears; internal reset clears all four flags even over an event
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rxrdy_reg <= 1'b0;
            pe_reg <= 1'b0;
            oe_reg <= 1'b0;
            syn_reg <= 1'b0;
            rx_data_reg <= SSMC_BYTE_ZERO;
            tx_busy_reg <= 1'b0;
        end else if (ireset) begin
            {rxrdy_reg, pe_reg, oe_reg, syn_reg} <= 4'h0; // R6
        end else begin
            if (rx_ev) begin
                rx_data_reg <= rx_char_reg;
                rxrdy_reg <= 1'b1;
            end else if (dat_rd || !cmd_reg[CMD_RX_EN]) begin
                rxrdy_reg <= 1'b0;
            end
            if (rx_ev && rx_perr_reg) begin
                pe_reg <= 1'b1;
            end else if (ctl_wr && seq_reg == SSMC_ST_CMD &&
                    wr_data[CMD_ERR_RST]) begin
                pe_reg <= 1'b0; // R19
            end
            if (rx_ev && rxrdy_reg && !dat_rd) begin
                oe_reg <= 1'b1;
            end else if (ctl_wr && seq_reg == SSMC_ST_CMD &&
                    wr_data[CMD_ERR_RST]) begin
                oe_reg <= 1'b0; // R19
            end
            if (sy_ev) begin
                syn_reg <= 1'b1;
            end else if (ctl_rd) begin
                syn_reg <= 1'b0; // R23
            end
            if (dat_wr) begin
                tx_busy_reg <= 1'b1;
            end else if (txw_tgl_reg == tk_s_reg) begin
                tx_busy_reg <= 1'b0;
            end
        end
    end

    // Registered read data; one cycle after rd_stb
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_data <= SSMC_BYTE_ZERO;
        end else if (dat_rd) begin
            rd_data <= rx_data_reg; // R7
        end else if (ctl_rd) begin
            rd_data <= '0;
            rd_data[ST_TXRDY] <= !tx_busy_reg;
            rd_data[ST_RXRDY] <= rxrdy_reg;
            rd_data[ST_TXEMPTY] <= !tx_busy_reg;
            rd_data[ST_PE] <= pe_reg;
            rd_data[ST_OE] <= oe_reg;
            rd_data[ST_SYNC] <= syn_reg;
            rd_data[ST_DSR] <= !ds_s_reg;
        end
    end

    // Pin is driven only in internal sync mode
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_found_oe_n <= 1'b0;
        end else begin
            sync_found_oe_n <= mode_reg[MODE_EXT_SYNC]; // R13
        end
    end

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    a_mode_after_reset: assert property (@(posedge ref_clk) // R6
        disable iff (reset) ireset |=> seq_reg == SSMC_ST_MODE)
        else $error("internal reset did not return to mode");
    a_first_mode: assert property (@(posedge ref_clk) // R2
        disable iff (reset)
        ctl_wr && seq_reg == SSMC_ST_MODE |=> mode_reg == $past(wr_data))
        else $error("mode word not captured");
    a_dtr_inverted: assert property (@(posedge ref_clk) // R16
        disable iff (reset)
        ctl_wr && seq_reg == SSMC_ST_CMD && !wr_data[CMD_IRESET]
        |=> ##1 dtr_n == !$past(wr_data[CMD_DTR], 2))
        else $error("terminal ready not inverted");
    a_rts_inverted: assert property (@(posedge ref_clk) // R20
        disable iff (reset) ##1 rts_n == !$past(cmd_reg[CMD_RTS]))
        else $error("request to send not inverted");
    a_err_clear: assert property (@(posedge ref_clk) // R19
        disable iff (reset)
        ctl_wr && seq_reg == SSMC_ST_CMD && wr_data[CMD_ERR_RST] && !rx_ev
        |=> !pe_reg && !oe_reg)
        else $error("error flags not cleared");
    a_sync_read_clr: assert property (@(posedge ref_clk) // R23
        disable iff (reset) ctl_rd && !sy_ev && !ireset |=> !syn_reg)
        else $error("sync status not cleared by read");
    a_sync_cmd_seq: assert property (@(posedge ref_clk) // R4
        disable iff (reset)
        ctl_wr && seq_reg == SSMC_ST_SYNC2 |=> seq_reg == SSMC_ST_CMD)
        else $error("commands not entered after syncs");
    a_pin_dir: assert property (@(posedge ref_clk) // R13
        disable iff (reset)
        ##1 sync_found_oe_n == $past(mode_reg[MODE_EXT_SYNC]))
        else $error("sync pin direction wrong");
endmodule
`default_nettype wire

// ---- dv/ssmc_modem.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssmc_modem (
    output logic link_clk,
    output logic rx_line
);
    // ------------------------------------------------
    // Modem bit clock and receive data
    // ------------------------------------------------
    // Free-running: a sync link keeps clocking fill characters
    initial begin
        link_clk = 1'b0;
        #17;
        forever #40 link_clk = ~link_clk;
    end
    initial rx_line = 1'b1;
    // Bits move on the falling edge, LSB first, settled for the rising edge
    task automatic send(input logic [23:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge link_clk);
            rx_line = w[i];
        end
        @(negedge link_clk);
        rx_line = 1'b1; // Back to mark between frames
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_sync_serial_mode_command_setup.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    n_errors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_sync_serial_mode_command_setup;
    import ssmc_pkg::*;
    logic ref_clk, reset, alt_sel, wr_stb, rd_stb, dsr_n, sync_found_in;
    logic [9:0] addr;
    logic [7:0] wr_data, rd_data, last;
    wire logic link_clk, rx_line, tx_line, dtr_n, rts_n;
    wire logic sync_found_out, sync_found_oe_n;
    int n_errors = 0;
    int checks_done = 0;
    // Rows: command byte, expected dtr_n, expected rts_n
    logic [9:0] rows [4] = '{10'h003, 10'h009, 10'h082, 10'h09C};
    ssmc_core i_ssmc_core (.ref_clk(ref_clk), .reset(reset),
        .alt_sel(alt_sel), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .wr_data(wr_data), .rd_data(rd_data), .link_clk(link_clk),
        .rx_line(rx_line), .tx_line(tx_line), .dsr_n(dsr_n),
        .dtr_n(dtr_n), .rts_n(rts_n), .sync_found_in(sync_found_in),
        .sync_found_out(sync_found_out), .sync_found_oe_n(sync_found_oe_n));
    ssmc_modem i_ssmc_modem (.link_clk(link_clk), .rx_line(rx_line));
    // ------------------------------------------------
    // Bus cycles and closing
    // ------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    // Read data is registered, so it is looked at one edge later
    task automatic rd(input logic [9:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard, far beyond the few microseconds the run needs
    initial begin
        #200us;
        n_errors++;
        summarize();
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        reset = 1'b1; alt_sel = 1'b0; addr = '0; wr_stb = 1'b0;
        rd_stb = 1'b0; wr_data = '0; dsr_n = 1'b0; sync_found_in = 1'b0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        wr(SSMC_CTRL_PRI, 8'h0C);
        wr(SSMC_CTRL_PRI, 8'h32);
        wr(SSMC_CTRL_PRI, 8'h32);
        for (int i = 0; i < 4; i++) begin
            wr(SSMC_CTRL_PRI, rows[i][9:2]);
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK("dtr_n", rows[i][1], dtr_n)
            `CHK("rts_n", rows[i][0], rts_n)
            $display("test command %h done", rows[i][9:2]);
        end
        // Break forces space; idle without data is mark
        wr(SSMC_CTRL_PRI, 8'h09);
        repeat (6) @(posedge link_clk);
        `CHK("tx_line", 1'b0, tx_line)
        wr(SSMC_CTRL_PRI, 8'h01);
        repeat (6) @(posedge link_clk);
        `CHK("tx_line", 1'b1, tx_line)
        $display("test break done");
        // Hunt: one pattern alone must not declare sync
        wr(SSMC_CTRL_PRI, 8'h84);
        fork
            i_ssmc_modem.send(24'hA53232, 24);
            begin
                repeat (11) @(posedge link_clk);
                `CHK("sync_mid", 1'b0, sync_found_out)
            end
        join
        repeat (4) @(posedge link_clk);
        `CHK("sync_found_out", 1'b1, sync_found_out)
        rd(SSMC_DATA_PRI);
        `CHK("rx_char", 8'hA5, rd_data)
        rd(SSMC_CTRL_PRI);
        `CHK("st_sync", 1'b1, rd_data[ST_SYNC])
        `CHK("st_dsr", 1'b1, rd_data[ST_DSR])
        last = rd_data;
        rd(10'h3A0);
        `CHK("unmapped", last, rd_data)
        rd(SSMC_CTRL_PRI);
        `CHK("st_sync_clr", 1'b0, rd_data[ST_SYNC])
        $display("test hunt done");
        // Internal reset on the alternate set, external sync mode
        alt_sel <= 1'b1;
        wr(SSMC_CTRL_ALT, 8'h40);
        wr(SSMC_CTRL_ALT, 8'h78);
        wr(SSMC_CTRL_ALT, 8'h32);
        wr(SSMC_CTRL_ALT, 8'h32);
        wr(SSMC_CTRL_ALT, 8'h33);
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK("oe_n_ext", 1'b1, sync_found_oe_n)
        `CHK("dtr_alt", 1'b0, dtr_n)
        // 7-bit even parity character; link reset long gone by now
        repeat (4) @(posedge link_clk);
        wr(SSMC_DATA_ALT, 8'h5B);
        repeat (5) @(posedge link_clk);
        for (int i = 0; i < 8; i++) begin
            @(negedge link_clk);
            last[i] = tx_line;
        end
        `CHK("tx_char", 8'hDB, last)
        $display("test alternate done");
        // External reset clears everything
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        `CHK("oe_n_rst", 1'b0, sync_found_oe_n)
        `CHK("dtr_rst", 1'b1, dtr_n)
        `CHK("rts_rst", 1'b1, rts_n)
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire
